// ==== vscp_partner.sv ====
`timescale 1ns/1ps
module vscp_partner (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    // System clock enable
    input  wire logic                        clkEn,
    // Link to the core
    vscp_if.partner                          link,
    // Source control
    input  wire logic                        startFrame,
    output logic                             frameBusy,
    // Sink control and captured pixels
    input  wire logic                        sinkReady,
    output logic                             rxStrobe,
    output logic [vscp_pkg::PIX_W-1:0]       rxData,
    output logic                             rxSof,
    output logic                             rxLineEndMarker,
    // Control master command port
    input  wire logic                        cmdValid,
    input  wire logic                        cmdWrite,
    input  wire logic [vscp_pkg::ADDR_W-1:0] cmdAddr,
    input  wire logic [vscp_pkg::DATA_W-1:0] cmdData,
    output logic                             cmdReady,
    output logic                             rspValid,
    output logic [vscp_pkg::DATA_W-1:0]      rspData,
    output logic [vscp_pkg::RESP_W-1:0]      rspResp
);

    typedef enum logic [4:0] {
        VSCP_IDLE  = 5'b00001,
        VSCP_WADDR = 5'b00010,
        VSCP_BWAIT = 5'b00100,
        VSCP_RADDR = 5'b01000,
        VSCP_RWAIT = 5'b10000
    } vscp_mst_t;

    localparam int PW = vscp_pkg::PIX_W;
    localparam int CW = vscp_pkg::CNT_W;
    localparam int RW = vscp_pkg::ROW_W;
    localparam int AW = vscp_pkg::ADDR_W;
    localparam int DW = vscp_pkg::DATA_W;

    // ==========================================================
    // Upstream source
    // ==========================================================
    logic          valid_q, valid_d;
    logic          sof_q, sof_d;
    logic          last_q, last_d;
    logic [PW-1:0] data_q, data_d;
    logic [CW-1:0] col_q, col_d;
    logic [RW-1:0] row_q, row_d;
    logic [CW-1:0] seed_q, seed_d;
    logic          srcTake;
    logic          endCol;

    assign link.inTvalid = valid_q;
    assign link.inTuser  = sof_q;
    assign link.inTlast  = last_q;
    assign link.inTdata  = data_q;
    assign frameBusy     = valid_q;
    assign srcTake = valid_q && link.inTready && clkEn;
    assign endCol  = (col_d == CW'(vscp_pkg::ACTIVE_COLS - 8'h01));

    always_comb begin
        valid_d = valid_q;
        col_d   = col_q;
        row_d   = row_q;
        seed_d  = seed_q;
        if (!valid_q && startFrame && clkEn) begin
            valid_d = 1'b1;
            col_d   = '0;
            row_d   = '0;
        end else if (srcTake) begin
            seed_d = seed_q + 8'h01;
            if (last_q) begin
                col_d = '0;
                row_d = row_q + 4'h1;
                if (row_q == RW'(vscp_pkg::ACTIVE_ROWS - 4'h1)) begin
                    valid_d = 1'b0;
                end
            end else begin
                col_d = col_q + 8'h01;
            end
        end
        // Only active samples; zero-filled upper lane bits
        data_d = vscp_pkg::packPixel(PW'({3{seed_d}}));
        sof_d  = valid_d && (col_d == '0) && (row_d == '0);
        last_d = valid_d && endCol;
        if (valid_q && !srcTake) begin
            data_d = data_q;
            sof_d  = sof_q;
            last_d = last_q;
        end
    end

    // ==========================================================
    // Downstream sink
    // ==========================================================
    logic          rxStrobe_q;
    logic [PW-1:0] rxData_q;
    logic          rxSof_q;
    logic          rxEnd_q;
    logic          snkTake;

    // Ready comes from the user alone, never from valid
    assign link.outTready = sinkReady;
    assign snkTake = link.outTvalid && sinkReady && clkEn;
    assign rxStrobe = rxStrobe_q;
    assign rxData   = rxData_q;
    assign rxSof    = rxSof_q;
    assign rxLineEndMarker = rxEnd_q;

    // ==========================================================
    // Control master, one transaction at a time
    // ==========================================================
    vscp_mst_t     mst_q, mst_d;
    logic [AW-1:0] addr_q, addr_d;
    logic [DW-1:0] wdat_q, wdat_d;
    logic          awDone_q, awDone_d;
    logic          wDone_q, wDone_d;
    logic          rspV_q, rspV_d;
    logic [DW-1:0] rspD_q, rspD_d;
    logic [1:0]    rspR_q, rspR_d;

    assign cmdReady     = (mst_q == VSCP_IDLE) && rst_n;
    assign link.awvalid = (mst_q == VSCP_WADDR) && !awDone_q;
    assign link.wvalid  = (mst_q == VSCP_WADDR) && !wDone_q;
    assign link.awaddr  = addr_q;
    assign link.wdata   = wdat_q;
    assign link.bready  = (mst_q == VSCP_BWAIT);
    assign link.arvalid = (mst_q == VSCP_RADDR);
    assign link.araddr  = addr_q;
    assign link.rready  = (mst_q == VSCP_RWAIT);
    assign rspValid = rspV_q;
    assign rspData  = rspD_q;
    assign rspResp  = rspR_q;

    always_comb begin
        mst_d    = mst_q;
        addr_d   = addr_q;
        wdat_d   = wdat_q;
        awDone_d = awDone_q;
        wDone_d  = wDone_q;
        rspV_d   = 1'b0;
        rspD_d   = rspD_q;
        rspR_d   = rspR_q;
        case (mst_q)
            VSCP_IDLE: begin
                if (cmdValid && clkEn) begin
                    addr_d   = cmdAddr;
                    wdat_d   = cmdData;
                    awDone_d = 1'b0;
                    wDone_d  = 1'b0;
                    mst_d = cmdWrite ? VSCP_WADDR : VSCP_RADDR;
                end
            end
            VSCP_WADDR: begin
                if (clkEn) begin
                    awDone_d = awDone_q || link.awready;
                    wDone_d  = wDone_q || link.wready;
                    if (awDone_d && wDone_d) begin
                        mst_d = VSCP_BWAIT;
                    end
                end
            end
            VSCP_BWAIT: begin
                if (link.bvalid && clkEn) begin
                    rspV_d = 1'b1;
                    rspD_d = '0;
                    rspR_d = link.bresp;
                    mst_d  = VSCP_IDLE;
                end
            end
            VSCP_RADDR: begin
                if (link.arready && clkEn) begin
                    mst_d = VSCP_RWAIT;
                end
            end
            VSCP_RWAIT: begin
                if (link.rvalid && clkEn) begin
                    rspV_d = 1'b1;
                    rspD_d = link.rdata;
                    rspR_d = link.rresp;
                    mst_d  = VSCP_IDLE;
                end
            end
            default: mst_d = VSCP_IDLE;
        endcase
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            valid_q <= 1'b0;
            sof_q <= 1'b0;
            last_q <= 1'b0;
            data_q <= '0;
            col_q <= '0;
            row_q <= '0;
            seed_q <= '0;
            rxStrobe_q <= 1'b0;
            rxData_q <= '0;
            rxSof_q <= 1'b0;
            rxEnd_q <= 1'b0;
            mst_q <= VSCP_IDLE;
            addr_q <= '0;
            wdat_q <= '0;
            awDone_q <= 1'b0;
            wDone_q <= 1'b0;
            rspV_q <= 1'b0;
            rspD_q <= '0;
            rspR_q <= '0;
        end else begin
            valid_q <= valid_d;
            sof_q <= sof_d;
            last_q <= last_d;
            data_q <= data_d;
            col_q <= col_d;
            row_q <= row_d;
            seed_q <= seed_d;
            rxStrobe_q <= snkTake;
            if (snkTake) begin
                rxData_q <= link.outTdata;
                rxSof_q  <= link.outTuser;
                rxEnd_q  <= link.outTlast;
            end
            mst_q <= mst_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            awDone_q <= awDone_d;
            wDone_q <= wDone_d;
            rspV_q <= rspV_d;
            rspD_q <= rspD_d;
            rspR_q <= rspR_d;
        end
    end

endmodule : vscp_partner

// ==== vscp_pkg.sv ====
// ==========================================================
// Stream and control port constants
// ==========================================================
package vscp_pkg;

    // Component and bus widths
    localparam int COMP_W  = 8;
    localparam int LANE_W  = ((COMP_W + 7) / 8) * 8;
    localparam int LANES   = 3;
    localparam int PIX_W   = LANES * LANE_W;
    localparam int ADDR_W  = 32;
    localparam int DATA_W  = 32;
    localparam int RESP_W  = 2;
    localparam int CNT_W   = 8;
    localparam int ROW_W   = 4;

    // Fixed picture geometry, set when the core is built
    localparam logic [CNT_W-1:0] ACTIVE_COLS = 8'h10;
    localparam logic [ROW_W-1:0] ACTIVE_ROWS = 4'h4;

    // Flush lengths in clock cycles
    localparam logic [CNT_W-1:0] LINE_FLUSH_CYC  = 8'h1a;
    localparam logic [CNT_W-1:0] FRAME_FLUSH_CYC =
        CNT_W'(ACTIVE_COLS + LINE_FLUSH_CYC);

    // Control slave build option and bus answers
    localparam logic              CTRL_PRESENT = 1'h0;
    localparam logic [RESP_W-1:0] RESP_OKAY    = 2'h0;
    localparam logic [RESP_W-1:0] RESP_DECERR  = 2'h3;

    // Zero-fill each component lane above the component width
    function automatic logic [PIX_W-1:0] packPixel(
        input logic [PIX_W-1:0] raw
    );
        logic [PIX_W-1:0] res;
        res = '0;
        for (int i = 0; i < LANES; i++) begin
            res[i*LANE_W +: COMP_W] = raw[i*LANE_W +: COMP_W];
        end
        return res;
    endfunction : packPixel

endpackage : vscp_pkg

// ==== vscp_if.sv ====
`timescale 1ns/1ps
// ==========================================================
// Stream and control link between core and partner
// ==========================================================
interface vscp_if;

    // Input stream, partner to core
    logic [vscp_pkg::PIX_W-1:0]  inTdata;
    logic                        inTvalid;
    logic                        inTready;
    logic                        inTuser;
    logic                        inTlast;

    // Output stream, core to partner
    logic [vscp_pkg::PIX_W-1:0]  outTdata;
    logic                        outTvalid;
    logic                        outTready;
    logic                        outTuser;
    logic                        outTlast;

    // Control slave, AXI4-Lite
    logic                        awvalid;
    logic                        awready;
    logic [vscp_pkg::ADDR_W-1:0] awaddr;
    logic                        wvalid;
    logic                        wready;
    logic [vscp_pkg::DATA_W-1:0] wdata;
    logic [vscp_pkg::RESP_W-1:0] bresp;
    logic                        bvalid;
    logic                        bready;
    logic                        arvalid;
    logic                        arready;
    logic [vscp_pkg::ADDR_W-1:0] araddr;
    logic                        rvalid;
    logic                        rready;
    logic [vscp_pkg::DATA_W-1:0] rdata;
    logic [vscp_pkg::RESP_W-1:0] rresp;

    modport device (
        input  inTdata, inTvalid, inTuser, inTlast, outTready,
        output inTready, outTdata, outTvalid, outTuser, outTlast,
        input  awvalid, awaddr, wvalid, wdata, bready,
        input  arvalid, araddr, rready,
        output awready, wready, bresp, bvalid,
        output arready, rvalid, rdata, rresp
    );

    modport partner (
        output inTdata, inTvalid, inTuser, inTlast, outTready,
        input  inTready, outTdata, outTvalid, outTuser, outTlast,
        output awvalid, awaddr, wvalid, wdata, bready,
        output arvalid, araddr, rready,
        input  awready, wready, bresp, bvalid,
        input  arready, rvalid, rdata, rresp
    );

endinterface : vscp_if

// ==== vscp_device.sv ====
`timescale 1ns/1ps
module vscp_device (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // System clock enable
    input  wire logic clkEn,
    // Link to the partner
    vscp_if.device    link,
    // Status
    output logic      frameActive
);

    // ==========================================================
    // Types and state
    // ==========================================================
    typedef enum logic [2:0] {
        VSCP_RUN    = 3'b001,
        VSCP_LFLUSH = 3'b010,
        VSCP_FFLUSH = 3'b100
    } vscp_state_t;

    localparam int PW = vscp_pkg::PIX_W;
    localparam int CW = vscp_pkg::CNT_W;
    localparam int RW = vscp_pkg::ROW_W;

    vscp_state_t   state_q;
    vscp_state_t   state_d;
    logic [CW-1:0] flushCnt_q;
    logic [CW-1:0] flushCnt_d;
    logic [RW-1:0] lineCnt_q;
    logic [RW-1:0] lineCnt_d;
    logic [RW-1:0] lineBase;
    logic          frameActive_q;
    logic          frameActive_d;

    logic [PW-1:0] memData_q [2];
    logic [PW-1:0] memData_d [2];
    logic [1:0]    memUser_q;
    logic [1:0]    memUser_d;
    logic [1:0]    memLast_q;
    logic [1:0]    memLast_d;
    logic          wrPtr_q;
    logic          wrPtr_d;
    logic          rdPtr_q;
    logic          rdPtr_d;
    logic [1:0]    count_q;
    logic [1:0]    count_d;

    logic          bvalid_q;
    logic          bvalid_d;
    logic          rvalid_q;
    logic          rvalid_d;

    logic          push;
    logic          pop;
    logic          bufFull;
    logic          lastLine;
    logic          wrTake;
    logic          rdTake;

    // ==========================================================
    // Handshakes
    // ==========================================================
    // Ready also waits on reset so nothing counts in reset
    assign bufFull = (count_q == 2'h2);
    assign link.inTready = rst_n && (state_q == VSCP_RUN)
                           && !bufFull;
    assign push = link.inTvalid && link.inTready && clkEn;
    assign link.outTvalid = (count_q != 2'h0);
    assign pop = link.outTvalid && link.outTready
                 && clkEn && rst_n;
    // Outputs read straight from buffer flops, held until pop
    assign link.outTdata = memData_q[rdPtr_q];
    assign link.outTuser = memUser_q[rdPtr_q];
    assign link.outTlast = memLast_q[rdPtr_q];
    assign frameActive   = frameActive_q;

    // ==========================================================
    // Two-entry buffer
    // ==========================================================
    // Two entries let the core take a pixel while the sink
    // stalls, so a late ready never drops a word
    always_comb begin
        memData_d = memData_q;
        memUser_d = memUser_q;
        memLast_d = memLast_q;
        wrPtr_d   = wrPtr_q;
        rdPtr_d   = rdPtr_q;
        count_d   = count_q;
        if (push) begin
            memData_d[wrPtr_q] =
                vscp_pkg::packPixel(link.inTdata);
            memUser_d[wrPtr_q] = link.inTuser;
            memLast_d[wrPtr_q] = link.inTlast;
            wrPtr_d = !wrPtr_q;
        end
        if (pop) begin
            rdPtr_d = !rdPtr_q;
        end
        case ({push, pop})
            2'b10:   count_d = count_q + 2'h1;
            2'b01:   count_d = count_q - 2'h1;
            default: count_d = count_q;
        endcase
    end

    // ==========================================================
    // Line and frame flush control
    // ==========================================================
    // Row count and flush lengths come from build constants; line ends come from inTlast, frame start from inTuser
    assign lineBase = link.inTuser ? '0 : lineCnt_q;
    assign lastLine = (lineBase ==
                       RW'(vscp_pkg::ACTIVE_ROWS - 4'h1));

    always_comb begin
        state_d       = state_q;
        flushCnt_d    = flushCnt_q;
        lineCnt_d     = lineCnt_q;
        frameActive_d = frameActive_q;
        if (push && link.inTuser) begin
            frameActive_d = 1'b1;
        end
        case (state_q)
            VSCP_RUN: begin
                if (push && link.inTlast) begin
                    if (lastLine) begin
                        state_d       = VSCP_FFLUSH;
                        flushCnt_d    = vscp_pkg::FRAME_FLUSH_CYC
                                        - 8'h01;
                        lineCnt_d     = '0;
                        frameActive_d = 1'b0;
                    end else begin
                        state_d    = VSCP_LFLUSH;
                        flushCnt_d = vscp_pkg::LINE_FLUSH_CYC
                                     - 8'h01;
                        lineCnt_d  = lineBase + 4'h1;
                    end
                end else if (push) begin
                    lineCnt_d = lineBase;
                end
            end
            VSCP_LFLUSH, VSCP_FFLUSH: begin
                // Counts only on enabled edges
                if (clkEn) begin
                    if (flushCnt_q == '0) begin
                        state_d = VSCP_RUN;
                    end else begin
                        flushCnt_d = flushCnt_q - 8'h01;
                    end
                end
            end
            default: state_d = VSCP_RUN;
        endcase
    end

    // ==========================================================
    // Control slave, omitted in this build
    // ==========================================================
    // Without the register file every access is answered with
    // a decode error, so a stray master never hangs the bus
    assign wrTake = link.awvalid && link.wvalid && !bvalid_q
                    && clkEn;
    assign rdTake = link.arvalid && !rvalid_q && clkEn;
    assign link.awready = link.awvalid && link.wvalid
                          && !bvalid_q && rst_n;
    assign link.wready  = link.awready;
    assign link.arready = !rvalid_q && rst_n;
    assign link.bvalid  = bvalid_q;
    assign link.rvalid  = rvalid_q;
    assign link.bresp   = vscp_pkg::CTRL_PRESENT ?
                          vscp_pkg::RESP_OKAY :
                          vscp_pkg::RESP_DECERR;
    assign link.rresp   = link.bresp;
    assign link.rdata   = '0;

    always_comb begin
        bvalid_d = bvalid_q;
        rvalid_d = rvalid_q;
        if (wrTake) begin
            bvalid_d = 1'b1;
        end else if (bvalid_q && link.bready && clkEn) begin
            bvalid_d = 1'b0;
        end
        if (rdTake) begin
            rvalid_d = 1'b1;
        end else if (rvalid_q && link.rready && clkEn) begin
            rvalid_d = 1'b0;
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    // Reset wins over enable; all else holds via the _d paths
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q       <= VSCP_RUN;
            flushCnt_q    <= '0;
            lineCnt_q     <= '0;
            frameActive_q <= 1'b0;
            memData_q[0]  <= '0;
            memData_q[1]  <= '0;
            memUser_q     <= '0;
            memLast_q     <= '0;
            wrPtr_q       <= 1'b0;
            rdPtr_q       <= 1'b0;
            count_q       <= '0;
            bvalid_q      <= 1'b0;
            rvalid_q      <= 1'b0;
        end else begin
            state_q       <= state_d;
            flushCnt_q    <= flushCnt_d;
            lineCnt_q     <= lineCnt_d;
            frameActive_q <= frameActive_d;
            memData_q     <= memData_d;
            memUser_q     <= memUser_d;
            memLast_q     <= memLast_d;
            wrPtr_q       <= wrPtr_d;
            rdPtr_q       <= rdPtr_d;
            count_q       <= count_d;
            bvalid_q      <= bvalid_d;
            rvalid_q      <= rvalid_d;
        end
    end

endmodule : vscp_device

// ==== vscp_checker_sva.sv ====
`timescale 1ns/1ps
// ==========================================================
// Link checks
// ==========================================================
module vscp_checker (
    // Clock, reset, enable
    input wire logic                        clk_sys,
    input wire logic                        rst_n,
    input wire logic                        clkEn,
    // Streams
    input wire logic                        inTvalid,
    input wire logic                        inTready,
    input wire logic                        inTlast,
    input wire logic [vscp_pkg::PIX_W-1:0]  outTdata,
    input wire logic                        outTvalid,
    input wire logic                        outTready,
    // Control slave
    input wire logic                        awvalid,
    input wire logic                        awready,
    input wire logic                        bvalid,
    input wire logic [vscp_pkg::RESP_W-1:0] bresp,
    input wire logic                        arvalid,
    input wire logic                        arready,
    input wire logic                        rvalid,
    input wire logic [vscp_pkg::RESP_W-1:0] rresp
);
    wire push = inTvalid && inTready && clkEn;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    in_gate_a: assert property (
        disable iff (1'b0) !rst_n |-> !inTready) else $error("ready in reset");
    first_show_a: assert property (
        push && !outTvalid |=> outTvalid) else $error("pixel not shown");
    out_hold_a: assert property (
        outTvalid && !(outTready && clkEn) |=> outTvalid && $stable(outTdata))
        else $error("output changed before pop");
    line_flush_a: assert property (
        push && inTlast |=> !inTready [*8]) else $error("flush too short");
    freeze_a: assert property (
        !clkEn |=> $stable({outTvalid, outTdata, bvalid, rvalid}))
        else $error("state moved while disabled");
    reset_a: assert property (
        disable iff (1'b0) !rst_n |=> !outTvalid && !bvalid && !rvalid)
        else $error("reset ignored");
    write_resp_a: assert property (
        awvalid && awready && clkEn
        |=> bvalid && bresp == vscp_pkg::RESP_DECERR)
        else $error("bad write answer");
    read_resp_a: assert property (
        arvalid && arready && clkEn
        |=> rvalid && rresp == vscp_pkg::RESP_DECERR)
        else $error("bad read answer");
endmodule : vscp_checker

// ==== video_stream_and_control_ports_test.sv ====
`timescale 1ns/1ps
// ==========================================================
// Core facing partner, driven from both user sides
// ==========================================================
module video_stream_and_control_ports_test;
    logic clk_sys, rst_n, clkEn, startFrame, frameBusy, sinkReady;
    logic rxStrobe, rxSof, rxLineEndMarker, frameActive;
    logic cmdValid, cmdWrite, cmdReady, rspValid;
    logic [vscp_pkg::ADDR_W-1:0] cmdAddr;
    logic [vscp_pkg::DATA_W-1:0] cmdData, rspData;
    logic [vscp_pkg::RESP_W-1:0] rspResp;
    logic [vscp_pkg::PIX_W-1:0]  rxData, held;
    logic [7:0]                  prevByte;
    int mismatches, comparisons, pixCnt, lowRun;
    int runs[$];
    vscp_if link ();
    vscp_device i_vscp_device (.clk_sys, .rst_n, .clkEn, .link,
        .frameActive);
    vscp_partner i_vscp_partner (.clk_sys, .rst_n, .clkEn, .link,
        .startFrame, .frameBusy, .sinkReady, .rxStrobe, .rxData, .rxSof,
        .rxLineEndMarker, .cmdValid, .cmdWrite, .cmdAddr, .cmdData,
        .cmdReady, .rspValid, .rspData, .rspResp);
    vscp_checker i_vscp_checker (.clk_sys, .rst_n, .clkEn,
        .inTvalid(link.inTvalid), .inTready(link.inTready),
        .inTlast(link.inTlast), .outTdata(link.outTdata),
        .outTvalid(link.outTvalid), .outTready(link.outTready),
        .awvalid(link.awvalid), .awready(link.awready),
        .bvalid(link.bvalid), .bresp(link.bresp),
        .arvalid(link.arvalid), .arready(link.arready),
        .rvalid(link.rvalid), .rresp(link.rresp));
    task automatic chk(input bit ok, input string m);
        comparisons++;
        if (!ok) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic tally_and_finish();
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic start_frame();
        pixCnt = 0;
        runs = {};
        // Drop any ready-low run left from reset or an earlier frame
        lowRun = 0;
        startFrame = 1;
        tick(1);
        startFrame = 0;
    endtask : start_frame
    // Bounded: a hung source shows up as a short pixel count
    task automatic wait_idle();
        for (int i = 0; i < 600; i++) begin
            if (frameBusy === 1'b0 && link.inTready === 1'b1) break;
            tick(1);
        end
        tick(3);
    endtask : wait_idle
    task automatic frame_plain();
        start_frame();
        wait_idle();
        chk(pixCnt == 64 && frameActive === 1'b0, "pixel count");
        chk(runs.size() == 4, "flush count");
        for (int i = 0; i < 3; i++) chk(runs[i] == 26, "line flush");
        chk(runs[3] == 16 + 26, "frame flush");
    endtask : frame_plain
    task automatic frame_stalled();
        sinkReady = 0;
        start_frame();
        tick(6);
        chk(link.inTready === 1'b0 && frameActive === 1'b1, "full");
        held = link.outTdata;
        clkEn = 0;
        sinkReady = 1;
        tick(8);
        chk(link.outTdata === held && rxStrobe === 1'b0, "frozen");
        clkEn = 1;
        sinkReady = 0;
        tick(4);
        chk(link.outTvalid === 1'b1 && link.outTdata === held, "held");
        sinkReady = 1;
        wait_idle();
        chk(pixCnt == 64, "pixel lost");
    endtask : frame_stalled
    task automatic reset_frozen();
        start_frame();
        tick(10);
        clkEn = 0;
        rst_n = 0;
        tick(1);
        chk(link.outTvalid === 1'b0 && link.inTready === 1'b0, "reset");
        rst_n = 1;
        clkEn = 1;
        tick(2);
    endtask : reset_frozen
    task automatic ctrl_access();
        for (int i = 0; i < 2; i++) begin
            cmdWrite = (i == 0);
            cmdAddr = (i == 0) ? 32'h0000_0000 : 32'h0000_0100;
            cmdData = 32'h0000_0004;
            cmdValid = 1;
            for (int k = 0; k < 20 && cmdReady !== 1'b1; k++) tick(1);
            tick(1);
            cmdValid = 0;
            for (int k = 0; k < 20 && rspValid !== 1'b1; k++) tick(1);
            chk(rspValid === 1'b1 && rspResp === 2'h3, "ctrl answer");
            chk(i == 0 || rspData === 32'h0000_0000, "read data");
            tick(1);
        end
    endtask : ctrl_access
    always @(posedge clk_sys) begin
        if (rxStrobe === 1'b1) begin
            chk(rxSof === (pixCnt == 0), "frame start");
            chk(rxLineEndMarker === (pixCnt % 16 == 15), "line end");
            chk(rxData === {3{rxData[7:0]}} && (pixCnt == 0 ||
                rxData[7:0] === prevByte + 8'h01), "pixel data");
            prevByte = rxData[7:0];
            pixCnt++;
        end
        if (link.inTready === 1'b0) lowRun++;
        else if (lowRun != 0) begin
            runs.push_back(lowRun);
            lowRun = 0;
        end
    end
    initial begin
        clk_sys = 0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        #200us;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        {rst_n, startFrame, cmdValid, cmdWrite, lowRun} = '0;
        {clkEn, sinkReady} = 2'h3;
        {cmdAddr, cmdData} = '0;
        tick(6);
        rst_n = 1;
        frame_plain();
        frame_stalled();
        reset_frozen();
        frame_plain();
        ctrl_access();
        tally_and_finish();
    end
endmodule : video_stream_and_control_ports_test
